// file: logic/datapath_fifo_status_load.sv
// Notes on behaviour
// - each fifo drives bus and block status
// - bus status serves as cpu interrupt request
// - input, level 0: bus high when room
// - input, level 1: bus needs two free
// - input: block status flags empty
// - output, level 0: bus high when data
// - output, level 1: bus needs two bytes
// - output: block status flags full
// - level bits live in aux control register
// - simultaneous read and write both apply
// - load sampled on datapath or fast clock
// - level mode stores while request high
// - edge mode stores once per rise
// - one bit sets mode for both fifos
// - edge detect runs at sampling rate
// - four bytes, cleared to zero at reset
// - source select picks bus or datapath source
`timescale 1ns/1ns
`default_nettype none
module datapath_fifo_status_load
  import fifo_status_pkg::*;
#(
  parameter int unsigned DP_DIV = fifo_status_pkg::DP_DIV_DEFAULT
)
(
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // datapath sources
  input  wire logic [7:0]  i_accumulator_zero,
  input  wire logic [7:0]  i_accumulator_one,
  input  wire logic [7:0]  i_alu_result,
  // datapath load and consume
  input  wire logic [1:0]  i_fifo_load_request,
  input  wire logic [1:0]  i_dp_consume,
  output logic      [7:0]  o_dp_data0,
  output logic      [7:0]  o_dp_data1,
  // status into routing
  output logic      [1:0]  o_bus_status,
  output logic      [1:0]  o_block_status
);
  import fifo_status_pkg::*;

  typedef struct packed
  {
    logic [7:0] aux_control_working_reg;
    logic [7:0] block_config_word_fifteen;
    logic [1:0] ld_prev;
    logic [7:0] rdata;
    logic [7:0] dp_data0;
    logic [7:0] dp_data1;
    logic [1:0] bus_stat;
    logic [1:0] blk_stat;
    logic [$clog2(DP_DIV)-1:0] div;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;

  logic [1:0][7:0]  fifo_rdata;
  logic [1:0][CNT_W-1:0] fifo_count;
  logic             dp_tick;
  logic             edge_mode;
  logic             fast_mode;
  logic             sample_en;

  // a divider of one would leave no slow tick to tell apart from fast mode
  if (DP_DIV < 2)
  begin : g_bad_div
    $error("datapath divider must be at least 2");
  end

  // datapath clock is an enable pulse from the divider
  assign dp_tick   = (st_r.div == '0);
  assign edge_mode = st_r.block_config_word_fifteen[CFG_EDGE_BIT];
  assign fast_mode = st_r.block_config_word_fifteen[CFG_FAST_BIT];
  // fast mode samples every system clock, otherwise the datapath tick
  assign sample_en = fast_mode ? 1'b1 : dp_tick;

  // per fifo source mux, load control and read side
  for (genvar f = 0; f < 2; f++)
  begin : g_fifo
    logic [1:0] fifo_source_select;
    logic       is_input;
    logic       ld_now;
    logic       bus_access;
    // per fifo strobes kept local so each process owns its own variables
    logic       fifo_write_pulse;
    logic       fifo_read;
    logic [7:0] fifo_wdata;
    assign fifo_source_select =
      st_r.block_config_word_fifteen[(f == 0 ? CFG_SEL0_LSB : CFG_SEL1_LSB) +: 2];
    assign is_input   = (fifo_source_select == SRC_BUS);
    assign ld_now     = i_fifo_load_request[f];
    assign bus_access = (i_addr == (f == 0 ? OFS_DATA0 : OFS_DATA1));

    // cpu writes in input mode, datapath loads in output mode
    always_comb
    begin
      unique case (fifo_source_select)
        SRC_BUS:      fifo_wdata = i_wdata;
        SRC_ACC_ZERO: fifo_wdata = i_accumulator_zero;
        SRC_ACC_ONE:  fifo_wdata = i_accumulator_one;
        SRC_ALU:      fifo_wdata = i_alu_result;
      endcase
      if (is_input)
      begin
        fifo_write_pulse = i_wr && bus_access;
        fifo_read        = i_dp_consume[f] && dp_tick;
      end
      else if (edge_mode)
      begin
        // one store per rise; low must be seen before next rise
        fifo_write_pulse = sample_en && ld_now && !st_r.ld_prev[f];
        fifo_read        = i_rd && bus_access;
      end
      else
      begin
        fifo_write_pulse = sample_en && ld_now;
        fifo_read        = i_rd && bus_access;
      end
    end

    byte_fifo4 #(
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .i_mclk  (i_mclk),
      .i_rst   (i_rst),
      .i_wr    (fifo_write_pulse),
      .i_wdata (fifo_wdata),
      .i_rd    (fifo_read),
      .o_rdata (fifo_rdata[f]),
      .o_count (fifo_count[f])
    );
  end

  // registers, status decode, edge history
  always_comb
  begin
    logic [CNT_W-1:0] cnt;
    logic             lvl;
    logic             inp;
    st_nxt = st_r;
    cnt    = '0;
    lvl    = 1'b0;
    inp    = 1'b0;
    st_nxt.div = (st_r.div == $clog2(DP_DIV)'(DP_DIV - 1)) ? '0 : st_r.div + 1'b1;
    // history updates only when sampled, so the edge is seen at that rate
    for (int f = 0; f < 2; f++)
    begin
      if (sample_en)
        st_nxt.ld_prev[f] = i_fifo_load_request[f];
    end
    if (i_wr)
    begin
      unique case (i_addr)
        OFS_AUX_CTRL: st_nxt.aux_control_working_reg   = i_wdata;
        OFS_CFG:      st_nxt.block_config_word_fifteen = i_wdata;
        default:      ;
      endcase
    end
    // read data stands the cycle after the strobe only
    st_nxt.rdata = 8'h00;
    if (i_rd)
    begin
      unique case (i_addr)
        OFS_AUX_CTRL: st_nxt.rdata = st_r.aux_control_working_reg;
        OFS_CFG:      st_nxt.rdata = st_r.block_config_word_fifteen;
        OFS_STATUS:   st_nxt.rdata = {4'h0, st_r.blk_stat, st_r.bus_stat};
        OFS_DATA0:    st_nxt.rdata = fifo_rdata[0];
        OFS_DATA1:    st_nxt.rdata = fifo_rdata[1];
        default:      st_nxt.rdata = 8'h00;
      endcase
    end
    // status from the fifo's registered count, applying direction and level
    for (int f = 0; f < 2; f++)
    begin
      cnt = fifo_count[f];
      lvl = st_r.aux_control_working_reg[f == 0 ? AUX_LVL0_BIT : AUX_LVL1_BIT];
      inp = (st_r.block_config_word_fifteen[(f == 0 ? CFG_SEL0_LSB : CFG_SEL1_LSB) +: 2] == SRC_BUS);
      if (inp)
      begin
        st_nxt.bus_stat[f] = lvl ? ((CNT_W'(FIFO_DEPTH) - cnt) >= CNT_W'(LEVEL_HALF))
                                 : (cnt != CNT_W'(FIFO_DEPTH));
        st_nxt.blk_stat[f] = (cnt == '0);
      end
      else
      begin
        st_nxt.bus_stat[f] = lvl ? (cnt >= CNT_W'(LEVEL_HALF)) : (cnt != '0);
        st_nxt.blk_stat[f] = (cnt == CNT_W'(FIFO_DEPTH));
      end
    end
    st_nxt.dp_data0 = fifo_rdata[0];
    st_nxt.dp_data1 = fifo_rdata[1];
  end

  // all control state in one register; reset is empty fifo status
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0;
      st_r.aux_control_working_reg   <= AUX_RESET;
      st_r.block_config_word_fifteen <= CFG_RESET;
      st_r.bus_stat <= 2'h3; // input mode, empty: room and
      st_r.blk_stat <= 2'h3; // empty both high
    end
    else
      st_r <= st_nxt;
  end

  assign o_rdata        = st_r.rdata;
  assign o_dp_data0     = st_r.dp_data0;
  assign o_dp_data1     = st_r.dp_data1;
  assign o_bus_status   = st_r.bus_stat;
  assign o_block_status = st_r.blk_stat;
endmodule : datapath_fifo_status_load
`default_nettype wire

// file: common/fifo_status_pkg.sv
`default_nettype none
package fifo_status_pkg;
  // fifo geometry
  localparam int unsigned FIFO_DEPTH    = 4;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned PTR_W         = 2;
  localparam int unsigned CNT_W         = 3;
  localparam int unsigned LEVEL_HALF    = 2;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  // source select encodings
  localparam logic [1:0]  SRC_BUS       = 2'h0;
  localparam logic [1:0]  SRC_ACC_ZERO  = 2'h1;
  localparam logic [1:0]  SRC_ACC_ONE   = 2'h2;
  localparam logic [1:0]  SRC_ALU       = 2'h3;
  // register offsets and fields
  localparam logic [3:0]  OFS_AUX_CTRL  = 4'h0;
  localparam logic [3:0]  OFS_CFG       = 4'h1;
  localparam logic [3:0]  OFS_STATUS    = 4'h2;
  localparam logic [3:0]  OFS_DATA0     = 4'h4;
  localparam logic [3:0]  OFS_DATA1     = 4'h5;
  localparam int unsigned AUX_LVL0_BIT  = 0;
  localparam int unsigned AUX_LVL1_BIT  = 1;
  localparam int unsigned CFG_SEL0_LSB  = 0;
  localparam int unsigned CFG_SEL1_LSB  = 2;
  localparam int unsigned CFG_EDGE_BIT  = 4;
  localparam int unsigned CFG_FAST_BIT  = 5;
  localparam logic [7:0]  AUX_RESET     = 8'h00;
  localparam logic [7:0]  CFG_RESET     = 8'h00;
  // datapath clock divider default
  localparam int unsigned DP_DIV_DEFAULT = 4;
endpackage : fifo_status_pkg
`default_nettype wire

// file: logic/byte_fifo4.sv
`timescale 1ns/1ns
`default_nettype none
module byte_fifo4
  import fifo_status_pkg::*;
#(
  parameter int unsigned DEPTH = fifo_status_pkg::FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  // write side
  input  wire logic              i_wr,
  input  wire logic [7:0]        i_wdata,
  // read side
  input  wire logic              i_rd,
  output logic      [7:0]        o_rdata,
  // status
  output logic      [CNT_W-1:0]  o_count
);
  typedef struct packed
  {
    logic [DEPTH-1:0][7:0] mem;
    logic [PTR_W-1:0]      wp;
    logic [PTR_W-1:0]      rp;
    logic [CNT_W-1:0]      cnt;
  } fifo_state_t;

  fifo_state_t st_r;
  fifo_state_t st_nxt;

  // pointer width is fixed by the package, so depth must fill it exactly
  if (DEPTH != (1 << PTR_W))
  begin : g_bad_depth
    $error("depth must match pointer width");
  end

  // pointers move independently; overflow overwrites the oldest byte
  always_comb
  begin
    st_nxt = st_r;
    if (i_wr)
    begin
      st_nxt.mem[st_r.wp] = i_wdata;
      st_nxt.wp = st_r.wp + PTR_W'(1);
    end
    if (i_rd)
      st_nxt.rp = st_r.rp + PTR_W'(1);
    // simultaneous read and write keeps the count
    if (i_wr && !i_rd && st_r.cnt != CNT_W'(DEPTH))
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
    else if (i_rd && !i_wr && st_r.cnt != CNT_W'(0))
      st_nxt.cnt = st_r.cnt - CNT_W'(1);
    else if (i_wr && !i_rd)
      st_nxt.rp = st_r.rp + PTR_W'(1); // full write pushes read side on
  end

  // contents clear to zero at reset
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_rdata = st_r.mem[st_r.rp];
  assign o_count = st_r.cnt;
endmodule : byte_fifo4
`default_nettype wire

// file: dv/fifo_status_checker.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_status_checker
  import fifo_status_pkg::*;
(
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_rst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // statuses
  input wire logic [1:0] o_bus_status,
  input wire logic [1:0] o_block_status
);
  logic [1:0] age_r;
  logic       out_r;
  logic       ok;
  logic       wr0;
  logic       rd0;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // status lags a setup write, so relations wait until it settles
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      age_r <= 2'h0;
    else if (i_wr && (i_addr == OFS_CFG || i_addr == OFS_AUX_CTRL))
      age_r <= 2'h0;
    else if (age_r != 2'h3)
      age_r <= age_r + 2'h1;
  // fifo0 direction shadow
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
      out_r <= 1'b0;
    else if (i_wr && i_addr == OFS_CFG)
      out_r <= (i_wdata[1:0] != SRC_BUS);
  // fifo0 bus strobes
  assign ok  = (age_r == 2'h3);
  assign wr0 = i_wr && i_addr == OFS_DATA0;
  assign rd0 = i_rd && i_addr == OFS_DATA0;
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("read data not idle");
  status_read_a: assert property (i_rd && i_addr == OFS_STATUS |=>
    o_rdata == {4'h0, $past(o_block_status), $past(o_bus_status)}) else $error("status read wrong");
  unmapped_read_a: assert property (i_rd && (i_addr == 4'h3 || i_addr > 4'h5) |=>
    o_rdata == 8'h00) else $error("unmapped read not zero");
  in_empty_room_a: assert property (ok && !out_r && o_block_status[0] |-> o_bus_status[0])
    else $error("empty without room");
  out_full_avail_a: assert property (ok && out_r && o_block_status[0] |-> o_bus_status[0])
    else $error("full without data");
  in_room_fall_a: assert property (ok && !out_r && $fell(o_bus_status[0]) |-> $past(wr0, 2))
    else $error("room lost without write");
  in_empty_fall_a: assert property (ok && !out_r && $fell(o_block_status[0]) |-> $past(wr0, 2))
    else $error("empty cleared without write");
  out_avail_fall_a: assert property (ok && out_r && $fell(o_bus_status[0]) |-> $past(rd0, 2))
    else $error("data lost without read");
  out_full_fall_a: assert property (ok && out_r && $fell(o_block_status[0]) |-> $past(rd0, 2))
    else $error("full cleared without read");
endmodule : fifo_status_checker
bind datapath_fifo_status_load fifo_status_checker fifo_status_checker_inst (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_bus_status(o_bus_status), .o_block_status(o_block_status));
`default_nettype wire

// file: dv/dp_partner.sv
`timescale 1ns/1ns
`default_nettype none
module dp_partner
(
  // clock
  input  wire logic       i_mclk,
  // datapath side
  output logic      [7:0] o_acc0,
  output logic      [7:0] o_acc1,
  output logic      [7:0] o_alu,
  output logic      [1:0] o_load,
  output logic      [1:0] o_consume
);
  // distinct source values expose a wrong source pick
  initial
  begin
    o_acc0    = 8'h3C;
    o_acc1    = 8'hC3;
    o_alu     = 8'h5A;
    o_load    = 2'h0;
    o_consume = 2'h0;
  end
  // fifo0 request, high for n edges, then low at least one edge
  task automatic drive(input logic cons, input int n);
    @(posedge i_mclk);
    o_load[0]    <= !cons;
    o_consume[0] <= cons;
    repeat (n) @(posedge i_mclk);
    o_load[0]    <= 1'b0;
    o_consume[0] <= 1'b0;
    @(posedge i_mclk);
  endtask : drive
  // fifo1 load request, same shape as fifo0
  task automatic drive_one(input int n);
    @(posedge i_mclk);
    o_load[1] <= 1'b1;
    repeat (n) @(posedge i_mclk);
    o_load[1] <= 1'b0;
    @(posedge i_mclk);
  endtask : drive_one
endmodule : dp_partner
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb;
  import fifo_status_pkg::*;
  logic       i_mclk;
  logic       i_rst;
  logic [3:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata, acc0, acc1, alu, dp0, dp1;
  logic [1:0] load, cons, bus, blk;
  int         n_mismatch;
  int         checks;
  datapath_fifo_status_load #(.DP_DIV(2)) datapath_fifo_status_load_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_accumulator_zero(acc0),
    .i_accumulator_one(acc1), .i_alu_result(alu), .i_fifo_load_request(load), .i_dp_consume(cons),
    .o_dp_data0(dp0), .o_dp_data1(dp1), .o_bus_status(bus), .o_block_status(blk));
  dp_partner dp_partner_inst (.i_mclk(i_mclk), .o_acc0(acc0), .o_acc1(acc1), .o_alu(alu), .o_load(load),
    .o_consume(cons));
  // free-running clock
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic test_done();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    `CHK(o_rdata, e)
  endtask : rdc
  // a hang counts as a mismatch
  initial
  begin
    #100000;
    n_mismatch++;
    test_done();
  end
  // status reads: {blk1, blk0, bus1, bus0}, fifo1 stays input and empty until the final alu output section
  initial
  begin
    i_rst      = 1'b1;
    i_addr     = 4'h0;
    i_wdata    = 8'h00;
    i_wr       = 1'b0;
    i_rd       = 1'b0;
    n_mismatch = 0;
    checks     = 0;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    rdc(OFS_STATUS, 8'h0F);
    `CHK(dp0, DATA_RESET)
    `CHK(dp1, DATA_RESET)
    wr(4'hF, 8'hFF);
    rdc(4'hF, 8'h00);
    wr(OFS_AUX_CTRL, 8'h01);
    wr(OFS_DATA0, 8'h11);
    wr(OFS_DATA0, 8'h22);
    rdc(OFS_STATUS, 8'h0B);
    wr(OFS_DATA0, 8'h33);
    rdc(OFS_STATUS, 8'h0A);
    wr(OFS_AUX_CTRL, 8'h00);
    rdc(OFS_STATUS, 8'h0B);
    wr(OFS_DATA0, 8'h44);
    rdc(OFS_STATUS, 8'h0A);
    `CHK(bus, 2'h2)
    `CHK(blk, 2'h2)
    `CHK(dp0, 8'h11)
    dp_partner_inst.drive(1'b1, 8);
    repeat (3) @(posedge i_mclk);
    rdc(OFS_STATUS, 8'h0F);
    // every output source, one byte per fast level sample
    for (int s = 1; s < 4; s++)
    begin
      wr(OFS_CFG, 8'h20 | 8'(s));
      dp_partner_inst.drive(1'b0, 1);
      rdc(OFS_DATA0, s == 1 ? acc0 : s == 2 ? acc1 : alu);
    end
    wr(OFS_AUX_CTRL, 8'h01);
    wr(OFS_CFG, 8'h32);
    dp_partner_inst.drive(1'b0, 3);
    rdc(OFS_STATUS, 8'h0A);
    dp_partner_inst.drive(1'b0, 3);
    rdc(OFS_STATUS, 8'h0B);
    wr(OFS_CFG, 8'h22);
    dp_partner_inst.drive(1'b0, 2);
    rdc(OFS_STATUS, 8'h0F);
    `CHK(bus, 2'h3)
    `CHK(blk, 2'h3)
    fork
      dp_partner_inst.drive(1'b0, 1);
      rdc(OFS_DATA0, acc1);
    join
    rdc(OFS_STATUS, 8'h0F);
    repeat (4) rdc(OFS_DATA0, acc1);
    rdc(OFS_STATUS, 8'h0A);
    // normal mode samples on datapath ticks only
    wr(OFS_CFG, 8'h01);
    dp_partner_inst.drive(1'b0, 4);
    repeat (3) @(posedge i_mclk);
    rdc(OFS_STATUS, 8'h0B);
    wr(OFS_CFG, 8'h11);
    dp_partner_inst.drive(1'b0, 4);
    repeat (3) @(posedge i_mclk);
    rdc(OFS_STATUS, 8'h0B);
    // fifo1 in output mode from the alu, fifo0 keeps its three bytes
    wr(OFS_CFG, 8'h2D);
    dp_partner_inst.drive_one(1);
    rdc(OFS_STATUS, 8'h03);
    `CHK(bus, 2'h3)
    `CHK(blk, 2'h0)
    `CHK(dp1, alu)
    rdc(OFS_DATA1, alu);
    test_done();
  end
endmodule : tb
`default_nettype wire
